// file: logic/indirect_decode.sv
// Decoder from a 16-bit file select pointer to a data or program memory address.
`timescale 1ns/1ps
`include "pcstk_map.svh"

module indirect_decode (
  // Pointer in
  input  wire logic [15:0]      ptr,
  // Decoded address out
  output pcstk_pkg::region_t    region,
  output logic      [11:0]      dmem_addr,
  output logic      [14:0]      pmem_addr,
  output logic                  self_ref
);

  logic [11:0] lin_ofs;
  logic [11:0] lin_bank;
  logic [11:0] lin_idx;

  always_comb begin
    lin_ofs  = 12'(ptr - `LIN_BASE);
    lin_bank = lin_ofs / `LIN_BLOCK;
    lin_idx  = lin_ofs % `LIN_BLOCK;
    pmem_addr = ptr[14:0];
    dmem_addr = ptr[11:0];
    region    = pcstk_pkg::REG_NONE;
    if (ptr[`PMEM_SEL_BIT]) begin
      region = pcstk_pkg::REG_PROG;
    end else if (ptr <= `TRAD_LAST) begin
      region = pcstk_pkg::REG_TRAD;
    end else if (ptr >= `LIN_BASE && ptr <= `LIN_LAST) begin
      // Common bytes are skipped: each bank contributes only its general block.
      region    = pcstk_pkg::REG_LIN;
      dmem_addr = 12'(lin_bank << `BANK_LSB) + `GPR_START + lin_idx;
    end
    self_ref = (region == pcstk_pkg::REG_TRAD) &&
               (ptr[`BANK_OFS_W-1:0] == `OFS_IND0 ||
                ptr[`BANK_OFS_W-1:0] == `OFS_IND1);
  end

endmodule

// file: logic/pc_stack_core.sv
// Program counter, hardware return stack, context copies and indirect access unit.
`timescale 1ns/1ps
`include "pcstk_map.svh"

module pc_stack_core #(
  parameter int          DEPTH     = 16,
  parameter logic [14:0] INT_VECTOR = 15'h0004
) (
  // Clock, reset, enable
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic               ce,
  // Configuration
  input  wire logic               stack_fault_reset_enable,
  // Instruction decoder events
  input  pcstk_pkg::pc_op_t       pc_op,
  input  wire logic [10:0]        operand,
  input  wire logic [7:0]         w_value,
  input  wire logic [7:0]         status_value,
  input  wire logic [7:0]         bank_value,
  // Core register port
  input  wire logic [11:0]        sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire logic [7:0]         sfr_wdata,
  output logic      [7:0]         sfr_rdata,
  // Indirect access request
  input  wire logic               ind_rd,
  input  wire logic               ind_wr,
  input  wire logic               ind_sel,
  input  wire logic [7:0]         ind_wdata,
  output logic      [7:0]         ind_rdata,
  output logic                    ind_done,
  output logic                    ind_stall,
  // Data and program memory
  output logic      [11:0]        dmem_addr,
  output logic                    dmem_rd,
  output logic                    dmem_wr,
  output logic      [7:0]         dmem_wdata,
  input  wire logic [7:0]         dmem_rdata,
  output logic      [14:0]        pmem_addr,
  output logic                    pmem_rd,
  input  wire logic [13:0]        pmem_rdata,
  // Counter, stack and power flags
  output logic      [14:0]        pc,
  output logic      [4:0]         stack_ptr,
  input  wire logic               stack_overflow_clr,
  input  wire logic               stack_underflow_clr,
  output logic                    stack_overflow_flag,
  output logic                    stack_underflow_flag,
  output logic                    stack_fault_reset,
  // Context restore to the core
  output logic                    ctx_restore,
  output logic      [7:0]         status_restore,
  output logic      [7:0]         working_restore,
  output logic      [7:0]         bank_restore
);

  // ****************************************
  // State
  // ****************************************
  logic [14:0] stack_mem [DEPTH];
  logic [14:0] pc_r, pc_nxt;
  logic [4:0]  sp_r, sp_nxt;
  logic [7:0]  latch_r, latch_nxt;
  logic [15:0] fsel0_r, fsel0_nxt, fsel1_r, fsel1_nxt;
  logic [7:0]  cp_stat_r, cp_stat_nxt, cp_work_r, cp_work_nxt, cp_bank_r, cp_bank_nxt;
  logic [7:0]  cp_latch_r, cp_latch_nxt;
  logic [15:0] cp_p0_r, cp_p0_nxt, cp_p1_r, cp_p1_nxt;
  logic        ovf_r, ovf_nxt, unf_r, unf_nxt;
  logic        fault_r, fault_nxt, restore_r, restore_nxt;
  logic        stk_we;
  logic [3:0]  stk_idx;
  logic [14:0] stk_wdata;
  logic [14:0] pc_inc;
  logic [14:0] top_entry;
  logic        push, pop, over, under;

  assign pc_inc    = pc_r + 15'h0001;
  assign top_entry = stack_mem[sp_r[3:0]];

  // ****************************************
  // Counter, stack and context
  // ****************************************
  always_comb begin
    pc_nxt       = pc_r;
    sp_nxt       = sp_r;
    latch_nxt    = latch_r;
    fsel0_nxt    = fsel0_r;
    fsel1_nxt    = fsel1_r;
    cp_stat_nxt  = cp_stat_r;
    cp_work_nxt  = cp_work_r;
    cp_bank_nxt  = cp_bank_r;
    cp_latch_nxt = cp_latch_r;
    cp_p0_nxt    = cp_p0_r;
    cp_p1_nxt    = cp_p1_r;
    restore_nxt  = 1'b0;
    fault_nxt    = 1'b0;
    stk_we       = 1'b0;
    stk_idx      = sp_r[3:0];
    stk_wdata    = pc_inc;
    push         = 1'b0;
    pop          = 1'b0;
    // Register writes first; a decoder event in the same cycle takes precedence, except that a stack top write sets what a call or computed call pushes.
    if (sfr_wr) begin
      case (sfr_addr)
        `OFS_CNT_LOW:       pc_nxt = {latch_r[6:0], sfr_wdata};
        `OFS_CNT_LATCH:     latch_nxt = sfr_wdata;
        `OFS_FSEL0_LOW:     fsel0_nxt[7:0] = sfr_wdata;
        `OFS_FSEL0_HIGH:    fsel0_nxt[15:8] = sfr_wdata;
        `OFS_FSEL1_LOW:     fsel1_nxt[7:0] = sfr_wdata;
        `OFS_FSEL1_HIGH:    fsel1_nxt[15:8] = sfr_wdata;
        `OFS_STATUS_COPY:   cp_stat_nxt = sfr_wdata;
        `OFS_WORK_COPY:     cp_work_nxt = sfr_wdata;
        `OFS_BANK_COPY:     cp_bank_nxt = sfr_wdata;
        `OFS_LATCH_COPY:    cp_latch_nxt = sfr_wdata;
        `OFS_P0L_COPY:      cp_p0_nxt[7:0] = sfr_wdata;
        `OFS_P0H_COPY:      cp_p0_nxt[15:8] = sfr_wdata;
        `OFS_P1L_COPY:      cp_p1_nxt[7:0] = sfr_wdata;
        `OFS_P1H_COPY:      cp_p1_nxt[15:8] = sfr_wdata;
        `OFS_STACK_PTR:     sp_nxt = sfr_wdata[4:0];
        `OFS_STACK_TOP_LOW: begin
          stk_we    = 1'b1;
          stk_wdata = {top_entry[14:8], sfr_wdata};
        end
        `OFS_STACK_TOP_HI:  begin
          stk_we    = 1'b1;
          stk_wdata = {sfr_wdata[6:0], top_entry[7:0]};
        end
        default:            pc_nxt = pc_r;
      endcase
    end
    case (pc_op)
      pcstk_pkg::OP_INC:   pc_nxt = pc_inc;
      pcstk_pkg::OP_CALL:  begin
        push   = 1'b1;
        pc_nxt = {latch_r[`LATCH_CALL_MSB:`LATCH_CALL_LSB], operand};
      end
      pcstk_pkg::OP_ICALL: begin
        push   = 1'b1;
        pc_nxt = {latch_r[6:0], w_value};
      end
      pcstk_pkg::OP_ABR:   pc_nxt = pc_inc + {7'h00, w_value};
      pcstk_pkg::OP_RJMP:  pc_nxt = pc_inc + 15'($signed(operand[`JMP_OFS_W-1:0]));
      pcstk_pkg::OP_RET:   pop = 1'b1;
      pcstk_pkg::OP_RETI:  begin
        pop         = 1'b1;
        restore_nxt = 1'b1;
        latch_nxt   = cp_latch_r;
        fsel0_nxt   = cp_p0_r;
        fsel1_nxt   = cp_p1_r;
      end
      pcstk_pkg::OP_INT:   begin
        push         = 1'b1;
        stk_wdata    = pc_r;
        pc_nxt       = INT_VECTOR;
        cp_stat_nxt  = status_value;
        cp_work_nxt  = w_value;
        cp_bank_nxt  = bank_value;
        cp_latch_nxt = latch_r;
        cp_p0_nxt    = fsel0_r;
        cp_p1_nxt    = fsel1_r;
      end
      default:             pc_nxt = pc_nxt;
    endcase
    over  = push && (sp_r == `SP_FULL);
    under = pop && (sp_r == `SP_EMPTY);
    if (push) begin
      sp_nxt  = sp_r + 5'h01;
      stk_we  = 1'b1;
      stk_idx = sp_nxt[3:0];
    end
    if (pop) begin
      pc_nxt = top_entry;
      sp_nxt = sp_r - 5'h01;
    end
    // Only the low nibble indexes the array, so a push past the top wraps to entry 0 while stack_fault_reset_enable is low.
    if ((over || under) && stack_fault_reset_enable) begin
      fault_nxt   = 1'b1;
      pc_nxt      = `PC_RESET;
      sp_nxt      = `SP_RESET;
      stk_we      = 1'b0;
      restore_nxt = 1'b0;
    end
    ovf_nxt = over || (ovf_r && !stack_overflow_clr);
    unf_nxt = under || (unf_r && !stack_underflow_clr);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_r       <= `PC_RESET;
      sp_r       <= `SP_RESET;
      latch_r    <= `BYTE_ZERO;
      fsel0_r    <= `PTR_ZERO;
      fsel1_r    <= `PTR_ZERO;
      cp_stat_r  <= `BYTE_ZERO;
      cp_work_r  <= `BYTE_ZERO;
      cp_bank_r  <= `BYTE_ZERO;
      cp_latch_r <= `BYTE_ZERO;
      cp_p0_r    <= `PTR_ZERO;
      cp_p1_r    <= `PTR_ZERO;
      ovf_r      <= 1'b0;
      unf_r      <= 1'b0;
      fault_r    <= 1'b0;
      restore_r  <= 1'b0;
    end else if (ce) begin
      pc_r       <= pc_nxt;
      sp_r       <= sp_nxt;
      latch_r    <= latch_nxt;
      fsel0_r    <= fsel0_nxt;
      fsel1_r    <= fsel1_nxt;
      cp_stat_r  <= cp_stat_nxt;
      cp_work_r  <= cp_work_nxt;
      cp_bank_r  <= cp_bank_nxt;
      cp_latch_r <= cp_latch_nxt;
      cp_p0_r    <= cp_p0_nxt;
      cp_p1_r    <= cp_p1_nxt;
      ovf_r      <= ovf_nxt;
      unf_r      <= unf_nxt;
      fault_r    <= fault_nxt;
      restore_r  <= restore_nxt;
    end
  end

  // Stack entries hold no reset value, which keeps them in plain storage.
  always_ff @(posedge clk_sys) begin
    if (ce && stk_we && !srst) begin
      stack_mem[stk_idx] <= stk_wdata;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd) begin
      case (sfr_addr)
        `OFS_CNT_LOW:       rdata_nxt = pc_r[7:0];
        `OFS_CNT_LATCH:     rdata_nxt = latch_r;
        `OFS_FSEL0_LOW:     rdata_nxt = fsel0_r[7:0];
        `OFS_FSEL0_HIGH:    rdata_nxt = fsel0_r[15:8];
        `OFS_FSEL1_LOW:     rdata_nxt = fsel1_r[7:0];
        `OFS_FSEL1_HIGH:    rdata_nxt = fsel1_r[15:8];
        `OFS_STATUS_COPY:   rdata_nxt = cp_stat_r;
        `OFS_WORK_COPY:     rdata_nxt = cp_work_r;
        `OFS_BANK_COPY:     rdata_nxt = cp_bank_r;
        `OFS_LATCH_COPY:    rdata_nxt = cp_latch_r;
        `OFS_P0L_COPY:      rdata_nxt = cp_p0_r[7:0];
        `OFS_P0H_COPY:      rdata_nxt = cp_p0_r[15:8];
        `OFS_P1L_COPY:      rdata_nxt = cp_p1_r[7:0];
        `OFS_P1H_COPY:      rdata_nxt = cp_p1_r[15:8];
        `OFS_STACK_PTR:     rdata_nxt = {3'h0, sp_r};
        `OFS_STACK_TOP_LOW: rdata_nxt = top_entry[7:0];
        `OFS_STACK_TOP_HI:  rdata_nxt = {1'b0, top_entry[14:8]};
        default:            rdata_nxt = `BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= `BYTE_ZERO;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Indirect access
  // ****************************************
  pcstk_pkg::region_t    dec_region;
  logic [11:0]           dec_daddr;
  logic [14:0]           dec_paddr;
  logic                  dec_self;
  pcstk_pkg::ind_state_t ist_r, ist_nxt;
  logic [11:0]           daddr_r, daddr_nxt;
  logic                  drd_r, drd_nxt, dwr_r, dwr_nxt;
  logic [7:0]            dwdata_r, dwdata_nxt, irdata_r, irdata_nxt;
  logic [14:0]           paddr_r, paddr_nxt;
  logic                  prd_r, prd_nxt, done_r, done_nxt, zero_r, zero_nxt, stl_r, stl_nxt;

  indirect_decode u_decode (
    .ptr       (ind_sel ? fsel1_r : fsel0_r),
    .region    (dec_region),
    .dmem_addr (dec_daddr),
    .pmem_addr (dec_paddr),
    .self_ref  (dec_self)
  );

  always_comb begin
    ist_nxt    = ist_r;
    daddr_nxt  = daddr_r;
    paddr_nxt  = paddr_r;
    dwdata_nxt = dwdata_r;
    irdata_nxt = irdata_r;
    zero_nxt   = zero_r;
    drd_nxt    = 1'b0;
    dwr_nxt    = 1'b0;
    prd_nxt    = 1'b0;
    done_nxt   = 1'b0;
    case (ist_r)
      pcstk_pkg::IND_IDLE: begin
        if (ind_rd || ind_wr) begin
          daddr_nxt  = dec_daddr;
          paddr_nxt  = dec_paddr;
          dwdata_nxt = ind_wdata;
          zero_nxt   = dec_self || (dec_region == pcstk_pkg::REG_NONE);
          if (dec_region == pcstk_pkg::REG_PROG) begin
            prd_nxt = ind_rd;
            ist_nxt = pcstk_pkg::IND_PROG1;
          end else begin
            drd_nxt = ind_rd && !zero_nxt;
            dwr_nxt = ind_wr && !zero_nxt;
            ist_nxt = pcstk_pkg::IND_DATA;
          end
        end
      end
      pcstk_pkg::IND_DATA: begin
        irdata_nxt = zero_r ? `BYTE_ZERO : dmem_rdata;
        done_nxt   = 1'b1;
        ist_nxt    = pcstk_pkg::IND_IDLE;
      end
      pcstk_pkg::IND_PROG1: begin
        irdata_nxt = pmem_rdata[7:0];
        ist_nxt    = pcstk_pkg::IND_PROG2;
      end
      pcstk_pkg::IND_PROG2: begin
        done_nxt = 1'b1;
        ist_nxt  = pcstk_pkg::IND_IDLE;
      end
      default: ist_nxt = pcstk_pkg::IND_IDLE;
    endcase
    stl_nxt = ist_nxt == pcstk_pkg::IND_PROG1;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ist_r    <= pcstk_pkg::IND_IDLE;
      daddr_r  <= 12'h000;
      paddr_r  <= 15'h0000;
      dwdata_r <= `BYTE_ZERO;
      irdata_r <= `BYTE_ZERO;
      zero_r   <= 1'b0;
      drd_r    <= 1'b0;
      dwr_r    <= 1'b0;
      prd_r    <= 1'b0;
      done_r   <= 1'b0;
      stl_r    <= 1'b0;
    end else if (ce) begin
      ist_r    <= ist_nxt;
      daddr_r  <= daddr_nxt;
      paddr_r  <= paddr_nxt;
      dwdata_r <= dwdata_nxt;
      irdata_r <= irdata_nxt;
      zero_r   <= zero_nxt;
      drd_r    <= drd_nxt;
      dwr_r    <= dwr_nxt;
      prd_r    <= prd_nxt;
      done_r   <= done_nxt;
      stl_r    <= stl_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pc                   = pc_r;
  assign stack_ptr            = sp_r;
  assign stack_overflow_flag  = ovf_r;
  assign stack_underflow_flag = unf_r;
  assign stack_fault_reset    = fault_r;
  assign ctx_restore          = restore_r;
  assign status_restore       = cp_stat_r;
  assign working_restore      = cp_work_r;
  assign bank_restore         = cp_bank_r;
  assign sfr_rdata            = rdata_r;
  assign ind_rdata            = irdata_r;
  assign ind_done             = done_r;
  assign ind_stall            = stl_r;
  assign dmem_addr            = daddr_r;
  assign dmem_rd              = drd_r;
  assign dmem_wr              = dwr_r;
  assign dmem_wdata           = dwdata_r;
  assign pmem_addr            = paddr_r;
  assign pmem_rd              = prd_r;

endmodule

// file: logic/pcstk_map.svh
// Register offsets, field positions, reset values and limits of the counter and stack block.
`ifndef PCSTK_MAP_SVH
`define PCSTK_MAP_SVH

// ****************************************
// Register offsets on the core register port
// ****************************************
`define OFS_IND0          7'h00
`define OFS_IND1          7'h01
`define OFS_CNT_LOW       12'h002
`define OFS_FSEL0_LOW     12'h004
`define OFS_FSEL0_HIGH    12'h005
`define OFS_FSEL1_LOW     12'h006
`define OFS_FSEL1_HIGH    12'h007
`define OFS_CNT_LATCH     12'h00a
`define OFS_STATUS_COPY   12'hfe4
`define OFS_WORK_COPY     12'hfe5
`define OFS_BANK_COPY     12'hfe6
`define OFS_LATCH_COPY    12'hfe7
`define OFS_P0L_COPY      12'hfe8
`define OFS_P0H_COPY      12'hfe9
`define OFS_P1L_COPY      12'hfea
`define OFS_P1H_COPY      12'hfeb
`define OFS_STACK_PTR     12'hfed
`define OFS_STACK_TOP_LOW 12'hfee
`define OFS_STACK_TOP_HI  12'hfef

// ****************************************
// Fields and reset values
// ****************************************
`define LATCH_CALL_MSB    6
`define LATCH_CALL_LSB    3
`define JMP_OFS_W         9
`define SP_RESET          5'h1f
`define SP_EMPTY          5'h1f
`define SP_FULL           5'h0f
`define PC_RESET          15'h0000
`define BYTE_ZERO         8'h00
`define PTR_ZERO          16'h0000

// ****************************************
// Indirect address regions
// ****************************************
`define PMEM_SEL_BIT      15
`define TRAD_LAST         16'h0fff
`define LIN_BASE          16'h2000
`define LIN_LAST          16'h29af
`define LIN_BLOCK         12'h050
`define GPR_START         12'h020
`define BANK_LSB          7
`define BANK_OFS_W        7

`endif

// file: logic/pcstk_pkg.sv
// Types shared by the counter, stack and indirect addressing logic.
package pcstk_pkg;

  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_INC   = 4'h1,
    OP_CALL  = 4'h2,
    OP_ICALL = 4'h3,
    OP_ABR   = 4'h4,
    OP_RJMP  = 4'h5,
    OP_RET   = 4'h6,
    OP_RETI  = 4'h7,
    OP_INT   = 4'h8
  } pc_op_t;

  typedef enum logic [1:0] {
    REG_TRAD = 2'h0,
    REG_LIN  = 2'h1,
    REG_PROG = 2'h2,
    REG_NONE = 2'h3
  } region_t;

  typedef enum logic [1:0] {
    IND_IDLE  = 2'h0,
    IND_DATA  = 2'h1,
    IND_PROG1 = 2'h2,
    IND_PROG2 = 2'h3
  } ind_state_t;

endpackage

// file: verif/mem_model.sv
// Behavioural data and program memory on the far side of the indirect access unit.
`timescale 1ns/1ps
module mem_model (
  // Clock
  input  wire logic        clk_sys,
  // Data memory
  input  wire logic [11:0] dmem_addr,
  input  wire logic        dmem_rd,
  input  wire logic        dmem_wr,
  output logic      [7:0]  dmem_rdata,
  // Program memory
  input  wire logic [14:0] pmem_addr,
  input  wire logic        pmem_rd,
  output logic      [13:0] pmem_rdata,
  // Observation
  output logic      [15:0] last_addr,
  output int               wr_count
);
  logic alt_r = 1'b0;
  initial wr_count = 0;
  initial last_addr = 16'hffff;
  // Outside a strobe the data lines toggle, so a stale sample cannot pass for a good one.
  assign dmem_rdata = dmem_rd ? (dmem_addr[7:0] ^ 8'h5a) : {8{alt_r}};
  assign pmem_rdata = pmem_rd ? {pmem_addr[13:8], pmem_addr[7:0] ^ 8'h3c} : {14{alt_r}};
  always @(posedge clk_sys) begin
    alt_r <= !alt_r;
    if (dmem_rd || dmem_wr) last_addr <= {4'h0, dmem_addr};
    if (pmem_rd) last_addr <= {1'b1, pmem_addr};
    if (dmem_wr) wr_count <= wr_count + 1;
  end
endmodule

// file: verif/pc_stack_sva.sv
// Checker of the counter, stack and indirect access ports.
`timescale 1ns/1ps
module pc_stack_sva (
  // Clock, reset, controls
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        stack_fault_reset_enable,
  input  pcstk_pkg::pc_op_t pc_op,
  input  wire logic [10:0] operand,
  input  wire logic [7:0]  w_value,
  // Observed outputs
  input  wire logic [14:0] pc,
  input  wire logic [4:0]  stack_ptr,
  input  wire logic        stack_overflow_flag,
  input  wire logic        stack_underflow_flag,
  input  wire logic        stack_fault_reset,
  input  wire logic        dmem_rd,
  input  wire logic        pmem_rd,
  input  wire logic        ind_done,
  input  wire logic        ind_stall
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic push;
  logic pop;
  logic ok;
  assign push = ce && pc_op inside {pcstk_pkg::OP_CALL, pcstk_pkg::OP_ICALL, pcstk_pkg::OP_INT};
  assign pop  = ce && pc_op inside {pcstk_pkg::OP_RET, pcstk_pkg::OP_RETI};
  assign ok   = !(stack_fault_reset_enable && stack_ptr == 5'h0f);
  reset_clear_a: assert property (disable iff (1'b0) srst |=> pc == 15'h0 && stack_ptr == 5'h1f)
    else $error("reset left counter or pointer set");
  call_target_a: assert property (ce && pc_op == pcstk_pkg::OP_CALL && ok |=> pc[10:0] == $past(operand))
    else $error("call target wrong");
  icall_low_a: assert property (ce && pc_op == pcstk_pkg::OP_ICALL && ok |=> pc[7:0] == $past(w_value))
    else $error("computed call low byte wrong");
  abr_sum_a: assert property (ce && pc_op == pcstk_pkg::OP_ABR |=> pc == $past(pc) + 15'h1 + {7'h0, $past(w_value)})
    else $error("accumulator branch target wrong");
  rjmp_sum_a: assert property (ce && pc_op == pcstk_pkg::OP_RJMP |=> pc == $past(pc) + 15'h1 + 15'($signed($past(operand[8:0]))))
    else $error("relative jump target wrong");
  push_ptr_a: assert property (push && ok && (stack_ptr < 5'h0f || stack_ptr == 5'h1f) |=> stack_ptr == $past(stack_ptr) + 5'h1)
    else $error("push did not step pointer up");
  pop_ptr_a: assert property (pop && stack_ptr <= 5'h0f |=> stack_ptr == $past(stack_ptr) - 5'h1)
    else $error("pop did not step pointer down");
  ovf_flag_a: assert property (push && stack_ptr == 5'h0f |=> stack_overflow_flag)
    else $error("overflow flag not set");
  unf_flag_a: assert property (pop && stack_ptr == 5'h1f |=> stack_underflow_flag)
    else $error("underflow flag not set");
  fault_reset_a: assert property (push && !ok |=> stack_fault_reset && pc == 15'h0 && stack_ptr == 5'h1f)
    else $error("stack fault did not reset");
  prog_extra_a: assert property (ce && pmem_rd |-> ind_stall ##2 ind_done)
    else $error("program read not stretched by one cycle");
  data_done_a: assert property (ce && dmem_rd |=> ind_done)
    else $error("data read not completed");
  wrap_c: cover property (push && stack_ptr == 5'h0f && ok);
  prog_c: cover property (pmem_rd);
  fault_c: cover property (stack_fault_reset);
endmodule
bind pc_stack_core pc_stack_sva u_sva (.clk_sys(clk_sys), .srst(srst), .ce(ce),
  .stack_fault_reset_enable(stack_fault_reset_enable), .pc_op(pc_op), .operand(operand),
  .w_value(w_value), .pc(pc), .stack_ptr(stack_ptr), .stack_overflow_flag(stack_overflow_flag),
  .stack_underflow_flag(stack_underflow_flag), .stack_fault_reset(stack_fault_reset),
  .dmem_rd(dmem_rd), .pmem_rd(pmem_rd), .ind_done(ind_done), .ind_stall(ind_stall));

// file: verif/testbench.sv
// Self-checking bench for the counter, stack and indirect access unit.
`timescale 1ns/1ps
`include "pcstk_map.svh"
module testbench;
  logic        clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, fen = 1'b0, ovc = 1'b0, unc = 1'b0;
  pcstk_pkg::pc_op_t pc_op = pcstk_pkg::OP_NONE;
  logic [10:0] operand = 11'h000;
  logic [7:0]  w_value = 8'h00, st_v = 8'h00, bk_v = 8'h00, sfr_wdata = 8'h00, ind_wdata = 8'h00;
  logic [11:0] sfr_addr = 12'h000;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0, ind_rd = 1'b0, ind_wr = 1'b0, ind_sel = 1'b0;
  logic [7:0]  sfr_rdata, ind_rdata, dmem_wdata, dmem_rdata, st_r, wk_r, bk_r;
  logic [11:0] dmem_addr;
  logic [14:0] pmem_addr, pc;
  logic [13:0] pmem_rdata;
  logic [4:0]  stack_ptr;
  logic        ind_done, ind_stall, dmem_rd, dmem_wr, pmem_rd, ovf, unf, frst, ctx_restore;
  logic [15:0] last_addr;
  int          wr_count, fail_count = 0, samples_checked = 0;
  always #50 clk_sys = ~clk_sys;
  pc_stack_core DUT (.clk_sys(clk_sys), .srst(srst), .ce(ce), .stack_fault_reset_enable(fen),
    .pc_op(pc_op), .operand(operand), .w_value(w_value), .status_value(st_v), .bank_value(bk_v),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .ind_rd(ind_rd), .ind_wr(ind_wr), .ind_sel(ind_sel),
    .ind_wdata(ind_wdata), .ind_rdata(ind_rdata), .ind_done(ind_done), .ind_stall(ind_stall),
    .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata),
    .pc(pc), .stack_ptr(stack_ptr), .stack_overflow_clr(ovc), .stack_underflow_clr(unc),
    .stack_overflow_flag(ovf), .stack_underflow_flag(unf), .stack_fault_reset(frst),
    .ctx_restore(ctx_restore), .status_restore(st_r), .working_restore(wk_r), .bank_restore(bk_r));
  mem_model u_mem (.clk_sys(clk_sys), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata),
    .last_addr(last_addr), .wr_count(wr_count));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic en);
    @(negedge clk_sys);
    fen = en;
    srst = 1'b1;
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
  endtask
  task automatic op(input pcstk_pkg::pc_op_t t, input logic [10:0] o, input logic [7:0] w);
    @(negedge clk_sys);
    pc_op = t;
    operand = o;
    w_value = w;
    @(negedge clk_sys);
    pc_op = pcstk_pkg::OP_NONE;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    chk("sfr_rdata", {8'h0, exp}, {8'h0, sfr_rdata});
  endtask
  // Address ffff: the last memory address is not compared.
  task automatic ind_chk(input logic [15:0] p, input logic w, input logic [7:0] e,
                         input logic [15:0] ea);
    int k, wc;
    wr(ind_sel ? `OFS_FSEL1_LOW : `OFS_FSEL0_LOW, p[7:0]);
    wr(ind_sel ? `OFS_FSEL1_HIGH : `OFS_FSEL0_HIGH, p[15:8]);
    wc = wr_count;
    @(negedge clk_sys);
    ind_rd = !w;
    ind_wr = w;
    ind_wdata = ~p[7:0];
    @(negedge clk_sys);
    ind_rd = 1'b0;
    ind_wr = 1'b0;
    k = 0;
    while (ind_done !== 1'b1 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    chk("ind_done", 16'h1, {15'h0, ind_done});
    if (w) chk("mem_writes", {15'h0, e[0]}, 16'(wr_count - wc));
    else chk("ind_rdata", {8'h0, e}, {8'h0, ind_rdata});
    if (w) chk("dmem_wdata", {8'h0, ~p[7:0]}, {8'h0, dmem_wdata});
    if (ea != 16'hffff) chk("mem_addr", ea, last_addr);
  endtask
  initial begin
    #(20000 * 100);
    fail_count++;
    test_done;
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    do_reset(1'b0);
    chk("pc", 16'h0000, {1'b0, pc});
    rd(`OFS_STACK_PTR, 8'h1f);
    wr(`OFS_CNT_LATCH, 8'h12);
    wr(`OFS_CNT_LOW, 8'h34);
    chk("pc", 16'h1234, {1'b0, pc});
    op(pcstk_pkg::OP_CALL, 11'h5a5, 8'h00);
    chk("pc", 16'h15a5, {1'b0, pc});
    chk("sp", 16'h0000, {11'h0, stack_ptr});
    rd(`OFS_STACK_TOP_LOW, 8'h35);
    rd(`OFS_STACK_TOP_HI, 8'h12);
    rd(`OFS_CNT_LATCH, 8'h12);
    op(pcstk_pkg::OP_ICALL, 11'h000, 8'h77);
    chk("pc", 16'h1277, {1'b0, pc});
    op(pcstk_pkg::OP_ABR, 11'h000, 8'hff);
    chk("pc", 16'h1377, {1'b0, pc});
    op(pcstk_pkg::OP_RJMP, 11'h1f0, 8'h00);
    chk("pc", 16'h1368, {1'b0, pc});
    op(pcstk_pkg::OP_RET, 11'h000, 8'h00);
    chk("pc", 16'h15a6, {1'b0, pc});
    op(pcstk_pkg::OP_RET, 11'h000, 8'h00);
    chk("pc", 16'h1235, {1'b0, pc});
    chk("sp", 16'h001f, {11'h0, stack_ptr});
    op(pcstk_pkg::OP_RET, 11'h000, 8'h00);
    chk("underflow", 16'h1, {15'h0, unf});
    do_reset(1'b0);
    wr(`OFS_CNT_LATCH, 8'h12);
    st_v = 8'ha5;
    bk_v = 8'h1c;
    op(pcstk_pkg::OP_INT, 11'h000, 8'h3c);
    chk("pc", 16'h0004, {1'b0, pc});
    rd(`OFS_STATUS_COPY, 8'ha5);
    rd(`OFS_WORK_COPY, 8'h3c);
    rd(`OFS_BANK_COPY, 8'h1c);
    rd(`OFS_LATCH_COPY, 8'h12);
    wr(`OFS_CNT_LATCH, 8'h00);
    op(pcstk_pkg::OP_RETI, 11'h000, 8'h00);
    chk("pc", 16'h0000, {1'b0, pc});
    chk("ctx_restore", 16'h1, {15'h0, ctx_restore});
    chk("bank_restore", 16'h1c, {8'h0, bk_r});
    chk("status_restore", 16'h00a5, {8'h0, st_r});
    chk("working_restore", 16'h003c, {8'h0, wk_r});
    rd(`OFS_CNT_LATCH, 8'h12);
    ind_chk(16'h0020, 1'b0, 8'h7a, 16'h0020);
    ind_chk(16'h2050, 1'b0, 8'hfa, 16'h00a0);
    ind_chk(16'h29af, 1'b0, 8'h35, 16'h0f6f);
    ind_chk(16'h8005, 1'b0, 8'h39, 16'h8005);
    ind_chk(16'h0001, 1'b0, 8'h00, 16'hffff);
    ind_chk(16'h29b0, 1'b0, 8'h00, 16'hffff);
    ind_chk(16'h0000, 1'b1, 8'h00, 16'hffff);
    ind_chk(16'h8005, 1'b1, 8'h00, 16'hffff);
    ind_sel = 1'b1;
    ind_chk(16'h0030, 1'b1, 8'h01, 16'h0030);
    do_reset(1'b0);
    for (int i = 0; i < 17; i++) op(pcstk_pkg::OP_CALL, 11'(i), 8'h00);
    chk("sp", 16'h0010, {11'h0, stack_ptr});
    chk("overflow", 16'h1, {15'h0, ovf});
    op(pcstk_pkg::OP_RET, 11'h000, 8'h00);
    chk("pc", 16'h0010, {1'b0, pc});
    do_reset(1'b1);
    for (int i = 0; i < 17; i++) op(pcstk_pkg::OP_CALL, 11'(i), 8'h00);
    chk("pc", 16'h0000, {1'b0, pc});
    chk("sp", 16'h001f, {11'h0, stack_ptr});
    chk("overflow", 16'h1, {15'h0, ovf});
    test_done;
  end
endmodule
